// *** hw/icm_mapper.sv ***
// icm_mapper: interrupt cause mapper for a four-queue network controller
// assumes all event inputs and the message acknowledge come from logic on clk
`timescale 1ns/1ps
`default_nettype none
`include "icm_regs.svh"

module icm_mapper
  import icm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire icm_bus_req_s bus_req,
  output logic [31:0] bus_rdata,
  // cause events, one-cycle pulses
  input wire logic [`ICM_NUM_Q-1:0] rx_evt,
  input wire logic [`ICM_NUM_Q-1:0] tx_evt,
  input wire logic tcp_timer_evt,
  input wire logic [`ICM_LEG_W-1:0] legacy_evt,
  // single line for legacy/msi mode
  output logic irq_line,
  // message write request toward the pcie posted write path
  output logic msix_req,
  output logic [`ICM_ENT_W-1:0] msix_vec,
  input wire logic msix_ack
);

  icm_state_s s_q;
  icm_state_s s_d;

  // outputs straight from the state flops
  assign bus_rdata = s_q.rdata;
  assign irq_line = s_q.irq;
  assign msix_req = (s_q.msg == ICM_MSG_WAIT);
  assign msix_vec = s_q.vec;

  // next state: causes, mapping, message engine, register port
  always_comb
  begin
    logic [`ICM_NUM_ENT-1:0] ev;
    logic [31:0] eset;
    logic [31:0] eclr;
    logic [`ICM_LEG_W-1:0] lclr;
    logic [`ICM_NUM_VEC-1:0] vset;
    logic [`ICM_NUM_VEC-1:0] vclr;
    logic [`ICM_NUM_VEC-1:0] ready;
    logic [`ICM_ENT_W-1:0] dst;
    logic [`ICM_ENT_W-1:0] pick;
    logic wr_eclr;
    s_d = s_q;
    ev = '0;
    eset = '0;
    eclr = '0;
    lclr = '0;
    vset = '0;
    vclr = '0;
    ready = '0;
    dst = '0;
    pick = '0;
    wr_eclr = bus_req.wr && (bus_req.addr == `ICM_OFS_EXT_CAUSE);
    s_d.rdata = '0;

    // cause vector laid out in allocation entry order
    for (int i = 0; i < `ICM_NUM_Q; i++)
    begin
      ev[2*i] = rx_evt[i];
      ev[2*i+1] = tx_evt[i];
    end
    ev[`ICM_NUM_ENT-2] = tcp_timer_evt;
    ev[`ICM_NUM_ENT-1] = |legacy_evt;

    // write-one-to-clear masks
    if (wr_eclr)
    begin
      eclr = bus_req.wdata;
    end
    if (bus_req.wr && (bus_req.addr == `ICM_OFS_LEG_CAUSE))
    begin
      lclr = bus_req.wdata[`ICM_LEG_W-1:0];
    end

    // legacy causes each own a bit; a new event beats a clear
    s_d.leg_cause = (s_q.leg_cause & ~lclr) | legacy_evt;

    // steer every queue cause through its allocation entry, timer and other only in multi-vector mode
    for (int k = 0; k < `ICM_NUM_ENT; k++)
    begin
      if (k < 2*`ICM_NUM_Q)
      begin
        dst = s_q.qalloc[`ICM_ENT_STRIDE*k +: `ICM_ENT_W];
      end
      else
      begin
        dst = s_q.malloc[`ICM_ENT_STRIDE*(k-2*`ICM_NUM_Q) +: `ICM_ENT_W];
      end
      if (ev[k])
      begin
        if (!s_q.mvs)
        begin
          // misc entry unused here; fixed bits cover timer and other
          if (k < 2*`ICM_NUM_Q)
          begin
            eset[dst[`ICM_QBIT_W-1:0]] = 1'b1;
          end
        end
        else if (dst < `ICM_ENT_W'(`ICM_NUM_VEC))
        begin
          // out-of-range vectors are dropped, not aliased
          eset[dst] = 1'b1;
          vset[dst] = 1'b1;
        end
      end
    end
    if (!s_q.mvs)
    begin
      eset[`ICM_TIMER_BIT] = tcp_timer_evt;
    end

    // sticky extended causes, set wins over clear
    s_d.ext_cause = (s_q.ext_cause & ~eclr) | eset;
    if (!s_q.mvs)
    begin
      // summary tracks the legacy bits level by level
      s_d.ext_cause[`ICM_OTHER_BIT] = |s_d.leg_cause;
    end

    // message engine: one posted write in flight at a time
    for (int v = `ICM_NUM_VEC-1; v >= 0; v--)
    begin
      if (s_q.pend[v] && s_q.ext_mask[v])
      begin
        pick = `ICM_ENT_W'(v); // lowest ready vector wins
      end
    end
    ready = s_q.pend & s_q.ext_mask[`ICM_NUM_VEC-1:0];
    unique case (s_q.msg)
      ICM_MSG_IDLE:
      begin
        if (s_q.mvs && (ready != '0))
        begin
          s_d.msg = ICM_MSG_WAIT;
          s_d.vec = pick;
        end
      end
      ICM_MSG_WAIT:
      begin
        if (msix_ack)
        begin
          vclr[s_q.vec] = 1'b1;
          s_d.msg = ICM_MSG_IDLE;
        end
        else if (!s_q.mvs)
        begin
          s_d.msg = ICM_MSG_IDLE;
        end
      end
    endcase
    // pending follows the ack; a new event on the same vector re-arms it
    s_d.pend = (s_q.pend & ~vclr) | vset;
    if (!s_q.mvs)
    begin
      s_d.pend = '0;
    end

    // register writes
    if (bus_req.wr)
    begin
      unique case (bus_req.addr)
        `ICM_OFS_CFG: s_d.mvs = bus_req.wdata[`ICM_MVS_BIT];
        `ICM_OFS_EXT_MASK: s_d.ext_mask = bus_req.wdata;
        `ICM_OFS_QALLOC: s_d.qalloc = bus_req.wdata;
        `ICM_OFS_MALLOC: s_d.malloc = bus_req.wdata;
        default: s_d.rdata = '0;
      endcase
    end

    // leaving multi-vector mode abandons a standing message on the same edge,
    // so the request never outlives the mode that raised it
    if (!s_d.mvs)
    begin
      s_d.msg = ICM_MSG_IDLE;
    end

    // register reads, data valid in the next cycle only
    if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        `ICM_OFS_CFG: s_d.rdata = 32'(s_q.mvs);
        `ICM_OFS_EXT_CAUSE: s_d.rdata = s_q.ext_cause;
        `ICM_OFS_EXT_MASK: s_d.rdata = s_q.ext_mask;
        `ICM_OFS_LEG_CAUSE: s_d.rdata = 32'(s_q.leg_cause);
        `ICM_OFS_QALLOC: s_d.rdata = s_q.qalloc;
        `ICM_OFS_MALLOC: s_d.rdata = s_q.malloc;
        `ICM_OFS_PEND: s_d.rdata = 32'(s_q.pend);
        default: s_d.rdata = '0; // unmapped reads as zero
      endcase
    end

    // single line only in legacy/msi mode
    s_d.irq = !s_d.mvs && ((s_d.ext_cause & s_d.ext_mask) != '0);
  end

  // state register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q.mvs <= 1'b0;
      s_q.ext_cause <= `ICM_RST_WORD;
      s_q.ext_mask <= `ICM_RST_WORD;
      s_q.leg_cause <= '0;
      s_q.qalloc <= `ICM_RST_WORD;
      s_q.malloc <= `ICM_RST_WORD;
      s_q.pend <= `ICM_RST_PEND;
      s_q.msg <= ICM_MSG_IDLE;
      s_q.vec <= '0;
      s_q.irq <= 1'b0;
      s_q.rdata <= `ICM_RST_WORD;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // checks on mapping and signalling
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_rx_map_bit: assert property (
    (!s_q.mvs && rx_evt[1]) |=> s_q.ext_cause[$past(s_q.qalloc[9:8])])
    else $error("rx queue 1 did not set its mapped cause bit");

  a_tx_map_bit: assert property (
    (!s_q.mvs && tx_evt[0]) |=> s_q.ext_cause[$past(s_q.qalloc[5:4])])
    else $error("tx queue 0 did not use entry 1");

  a_queue_low_bits: assert property (
    (!s_q.mvs && !$past(s_q.mvs) && !tcp_timer_evt && !wr_any_cause())
    |=> s_q.ext_cause[29:4] == $past(s_q.ext_cause[29:4]))
    else $error("queue cause reached a bit above 3");

  a_timer_bit30: assert property (
    (!s_q.mvs && tcp_timer_evt) |=> s_q.ext_cause[30])
    else $error("timer did not set bit 30");

  a_other_summary: assert property (
    (!s_q.mvs && (legacy_evt != '0)) |=> s_q.ext_cause[31] && (s_q.leg_cause != '0))
    else $error("other summary not reflected in bit 31");

  a_legacy_one_line: assert property (
    !s_q.mvs |-> (!msix_req && (irq_line == ((s_q.ext_cause & s_q.ext_mask) != '0))))
    else $error("legacy mode line does not follow unmasked causes");

  a_msix_rx_vec: assert property (
    (s_q.mvs && rx_evt[0] && (s_q.qalloc[2:0] < 3'h5))
    |=> s_q.pend[$past(s_q.qalloc[2:0])] && s_q.ext_cause[$past(s_q.qalloc[2:0])])
    else $error("rx queue 0 did not raise its vector");

  a_msix_timer_vec: assert property (
    (s_q.mvs && tcp_timer_evt && (s_q.malloc[2:0] < 3'h5))
    |=> s_q.pend[$past(s_q.malloc[2:0])])
    else $error("timer did not raise its misc vector");

  a_vec_range: assert property (
    msix_req |-> (msix_vec < 3'h5) && ($stable(msix_vec) || $rose(msix_req)))
    else $error("message vector out of range");

  a_cause_sticky: assert property (
    (s_q.ext_cause[0] && !(bus_req.wr && bus_req.addr == `ICM_OFS_EXT_CAUSE
      && bus_req.wdata[0])) |=> s_q.ext_cause[0])
    else $error("cause bit 0 dropped without a clear");

  // helper: any write to the extended cause register
  function automatic logic wr_any_cause();
    return bus_req.wr && (bus_req.addr == `ICM_OFS_EXT_CAUSE);
  endfunction

  c_legacy_irq: cover property (!s_q.mvs && rx_evt[0] ##1 irq_line);
  c_msix_done: cover property (msix_req && msix_ack ##1 !msix_req);
  c_timer_legacy: cover property (!s_q.mvs && tcp_timer_evt ##1 s_q.ext_cause[30]);

endmodule // icm_mapper

`default_nettype wire

// *** hw/icm_regs.svh ***
// icm_regs.svh: offsets, field positions and reset values of the cause mapper
// assumes byte offsets on an 8-bit register address, 32-bit data
`ifndef ICM_REGS_SVH
`define ICM_REGS_SVH

// register address width and offsets
`define ICM_ADDR_W 8
`define ICM_OFS_CFG 8'h00
`define ICM_OFS_EXT_CAUSE 8'h04
`define ICM_OFS_EXT_MASK 8'h08
`define ICM_OFS_LEG_CAUSE 8'h0c
`define ICM_OFS_QALLOC 8'h10
`define ICM_OFS_MALLOC 8'h14
`define ICM_OFS_PEND 8'h18

// field positions
`define ICM_MVS_BIT 0
`define ICM_TIMER_BIT 30
`define ICM_OTHER_BIT 31
`define ICM_ENT_STRIDE 4
`define ICM_ENT_W 3
`define ICM_QBIT_W 2

// counts
`define ICM_NUM_Q 4
`define ICM_NUM_ENT 10
`define ICM_NUM_VEC 5
`define ICM_LEG_W 16

// reset values
`define ICM_RST_WORD 32'h0000_0000
`define ICM_RST_PEND 5'h00

`endif

// *** hw/icm_pkg.sv ***
// icm_pkg: types shared by the interrupt cause mapper
// assumes icm_regs.svh lies on the include path
`include "icm_regs.svh"

package icm_pkg;

  // message engine states, one bit, gray by construction
  typedef enum logic {
    ICM_MSG_IDLE = 1'b0,
    ICM_MSG_WAIT = 1'b1
  } icm_msg_e;

  // register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [`ICM_ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } icm_bus_req_s;

  // all state of the mapper
  typedef struct packed {
    logic mvs;
    logic [31:0] ext_cause;
    logic [31:0] ext_mask;
    logic [`ICM_LEG_W-1:0] leg_cause;
    logic [31:0] qalloc;
    logic [31:0] malloc;
    logic [`ICM_NUM_VEC-1:0] pend;
    icm_msg_e msg;
    logic [`ICM_ENT_W-1:0] vec;
    logic irq;
    logic [31:0] rdata;
  } icm_state_s;

endpackage

// *** verif/icm_host_model.sv ***
// icm_host_model: host end that takes message writes from the mapper
// assumes msix_req is a level held until ack, and shares clk with the mapper
`timescale 1ns/1ps
`default_nettype none

module icm_host_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // message port
  input wire logic msix_req,
  input wire logic slow,
  output logic msix_ack
);
  int cnt;

  // one ack pulse after a prompt or a slow wait
  // the pulse is lowered on the same edge that drops req, so one request is never taken twice
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      msix_ack <= 1'b0;
      cnt <= 0;
    end
    else if (msix_ack)
      msix_ack <= 1'b0;
    else if (msix_req && cnt >= (slow ? 6 : 0))
    begin
      msix_ack <= 1'b1;
      cnt <= 0;
    end
    else if (msix_req)
      cnt <= cnt + 1;
  end
endmodule // icm_host_model
`default_nettype wire

// *** verif/icm_mapper_test.sv ***
// icm_mapper_test: self-checking bench for the cause mapper
// assumes the host model on the message port and a 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
`include "icm_regs.svh"

module icm_mapper_test;
  import icm_pkg::*;
  logic clk, rst_n, irq_line, msix_req, msix_ack, tm, slow, m;
  icm_bus_req_s req;
  logic [31:0] rdata, qa, ms, ex, rnd;
  logic [3:0] rx, tx, r, t;
  logic [2:0] vec;
  logic [15:0] lg, l;
  int mismatches, checks;

  icm_mapper i_dut (.clk(clk), .rst_n(rst_n), .bus_req(req), .bus_rdata(rdata),
    .rx_evt(rx), .tx_evt(tx), .tcp_timer_evt(tm), .legacy_evt(lg),
    .irq_line(irq_line), .msix_req(msix_req), .msix_vec(vec), .msix_ack(msix_ack));
  icm_host_model i_host (.clk(clk), .rst_n(rst_n), .msix_req(msix_req), .slow(slow),
    .msix_ack(msix_ack));

  // compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task test_done;
    if (mismatches == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // one-cycle bus strobes, read data sampled in the cycle after
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  // event pulse of one cycle, sampled on the edge that lowers it
  task pulse(input logic [3:0] pr, pt, input logic pm, input logic [15:0] pl);
    @(posedge clk);
    rx <= pr;
    tx <= pt;
    tm <= pm;
    lg <= pl;
    @(posedge clk);
    rx <= 4'h0;
    tx <= 4'h0;
    tm <= 1'b0;
    lg <= 16'h0;
    #1;
  endtask

  // bounded wait for a request level
  task wait_lvl(input logic lv);
    int n;
    n = 0;
    while (msix_req !== lv)
    begin
      n++;
      if (n > 50)
      begin
        mismatches++;
        test_done;
      end
      @(posedge clk);
      #1;
    end
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    rst_n = 1'b0;
    req = '0;
    {rx, tx, tm, lg, slow} = '0;
    mismatches = 0;
    checks = 0;
    void'($urandom(32'h6dba2c00));
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, unmapped 1c reads zero
    for (int a = 0; a < 32; a += 4)
      rdchk(a[7:0], 32'h0);
    // legacy mode: random steering, masks and events against the model
    repeat (24)
    begin
      qa = $urandom;
      ms = $urandom;
      rnd = $urandom;
      {r, t, m} = rnd[8:0];
      l = rnd[25] ? rnd[24:9] : 16'h0;
      wr(`ICM_OFS_QALLOC, qa);
      wr(`ICM_OFS_EXT_MASK, ms);
      wr(`ICM_OFS_MALLOC, $urandom);
      ex = 32'h0;
      for (int i = 0; i < 4; i++)
      begin
        if (r[i]) ex[qa[8*i +: 2]] = 1'b1;
        if (t[i]) ex[qa[8*i+4 +: 2]] = 1'b1;
      end
      ex[30] = m;
      ex[31] = |l;
      pulse(r, t, m, l);
      chk({31'h0, irq_line}, {31'h0, |(ex & ms)});
      repeat (3) @(posedge clk);
      rdchk(`ICM_OFS_EXT_CAUSE, ex);
      rdchk(`ICM_OFS_LEG_CAUSE, {16'h0, l});
      wr(`ICM_OFS_LEG_CAUSE, 32'hffff);
      wr(`ICM_OFS_EXT_CAUSE, 32'hffff_ffff);
      rdchk(`ICM_OFS_EXT_CAUSE, 32'h0);
    end
    // multi-vector mode: every entry value, prompt and slow host
    wr(`ICM_OFS_CFG, 32'h1);
    wr(`ICM_OFS_EXT_MASK, 32'h1f);
    for (int v = 0; v < 8; v++)
    begin
      slow <= v[0];
      wr(`ICM_OFS_QALLOC, v);
      pulse(4'h1, 4'h0, 1'b0, 16'h0);
      if (v < 5)
      begin
        wait_lvl(1'b1);
        chk({29'h0, vec}, v);
        wait_lvl(1'b0);
        rdchk(`ICM_OFS_PEND, 32'h0);
      end
      rdchk(`ICM_OFS_EXT_CAUSE, (v < 5) ? (32'h1 << v) : 32'h0);
      wr(`ICM_OFS_EXT_CAUSE, 32'hffff_ffff);
    end
    // rx and tx of queue 0 at once, lowest vector first
    wr(`ICM_OFS_QALLOC, 32'h31);
    pulse(4'h1, 4'h1, 1'b0, 16'h0);
    for (int j = 0; j < 2; j++)
    begin
      wait_lvl(1'b1);
      chk({29'h0, vec}, 1 + 2 * j);
      wait_lvl(1'b0);
    end
    // timer and other summary through the misc entry
    wr(`ICM_OFS_MALLOC, 32'h42);
    for (int k = 0; k < 2; k++)
    begin
      pulse(4'h0, 4'h0, k == 0, {15'h0, k == 1});
      wait_lvl(1'b1);
      chk({29'h0, vec}, k ? 4 : 2);
      wait_lvl(1'b0);
    end
    // one vector granted: driver falls back to the legacy mapping mid-request
    wr(`ICM_OFS_EXT_CAUSE, 32'hffff_ffff);
    wr(`ICM_OFS_LEG_CAUSE, 32'hffff);
    wr(`ICM_OFS_QALLOC, 32'h2);
    pulse(4'h1, 4'h0, 1'b0, 16'h0);
    wait_lvl(1'b1);
    wr(`ICM_OFS_CFG, 32'h0);
    #1;
    chk({30'h0, msix_req, irq_line}, 32'h1);
    wr(`ICM_OFS_EXT_CAUSE, 32'hffff_ffff);
    pulse(4'h1, 4'h0, 1'b0, 16'h0);
    chk({30'h0, msix_req, irq_line}, 32'h1);
    rdchk(`ICM_OFS_EXT_CAUSE, 32'h4);
    rdchk(`ICM_OFS_PEND, 32'h0);
    test_done;
  end
endmodule // icm_mapper_test
`default_nettype wire
